//--- pkg/uhis_pkg.sv
// constants and types of the usb host interrupt event status block
// =====================================================================
package uhis_pkg;

  // =================================================================
  // register map
  localparam logic [7:0]  UHIS_OFS_FLAGS   = 8'h0c;
  localparam logic [31:0] UHIS_FLAGS_RESET = 32'h0000_0000;
  localparam logic [1:0]  UHIS_OVR_RESET   = 2'h0;
  localparam int          UHIS_OVR_LSB     = 16;

  // =================================================================
  // flag bit positions
  localparam int UHIS_BIT_OWN  = 30;
  localparam int UHIS_BIT_RHUB = 6;
  localparam int UHIS_BIT_FWRP = 5;
  localparam int UHIS_BIT_FATL = 4;
  localparam int UHIS_BIT_RSM  = 3;
  localparam int UHIS_BIT_SOF  = 2;
  localparam int UHIS_BIT_DONE = 1;
  localparam int UHIS_BIT_OVR  = 0;

  // implemented flags; all others are reserved and read zero
  localparam logic [31:0] UHIS_IMPL_MASK = 32'h4000_007f;

  // =================================================================
  // state of the main block
  typedef struct packed {
    logic [31:0] flags;
    logic [1:0]  ovr_cnt;
    logic        ovr_pend;
    logic [31:0] rdata;
  } uhis_state_t;

  // state of the edge detector
  typedef struct packed {
    logic prev;
    logic armed;
  } uhis_edge_state_t;

endpackage

//--- tb/uhis_host_model.sv
// host driver model: strobe-port reads and writes of the flag register
`timescale 1ns/1ps
module uhis_host_model
  import uhis_pkg::*;
(
  // clock
  input  wire logic        sys_clk_i,
  // register port
  output logic             reg_wr_o,
  output logic             reg_rd_o,
  output logic [7:0]       reg_addr_o,
  output logic [31:0]      reg_wdata_o,
  input  wire logic [31:0] reg_rdata_i
);
  // idle port at time zero
  initial begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = 8'h00;
    reg_wdata_o = 32'h0000_0000;
  end

  // one write, then an idle cycle; reserved bits always sent as zero
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_o  = a;
    reg_wdata_o = d & UHIS_IMPL_MASK;
    reg_wr_o    = 1'b1;
    @(posedge sys_clk_i);
    #1;
    reg_wr_o    = 1'b0;
    reg_wdata_o = ~reg_wdata_o; // released data does not hold its value
    @(posedge sys_clk_i);
    #1;
  endtask

  // one read; data stands just after the taken edge, for one cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr_o = a;
    reg_rd_o   = 1'b1;
    @(posedge sys_clk_i);
    #1;
    reg_rd_o   = 1'b0;
    d          = reg_rdata_i;
    @(posedge sys_clk_i);
    #1;
  endtask
endmodule

//--- tb/usb_host_interrupt_status_test.sv
// self-checking bench of the interrupt event flag block
`timescale 1ns/1ps
module usb_host_interrupt_status_test
  import uhis_pkg::*;
;
  // =====================================================================
  // stimulus and observed signals
  logic        sys_clk_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        reg_wr, reg_rd;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [31:0] mask   = 32'h4000_007f;
  logic        master = 1'b0;
  logic        own_req = 1'b0, rhub = 1'b0, fupd = 1'b0, syserr = 1'b0;
  logic        rsm = 1'b0, rsm_sw = 1'b0, sof = 1'b0, done = 1'b0;
  logic        ovr = 1'b0;
  logic [15:0] fcnt = 16'h0000;
  logic        irq, smi, halt, allow;
  logic [1:0]  ocnt;
  logic [31:0] exp_f;
  int          err_total = 0;
  int          samples_checked = 0;

  // 100 MHz clock
  always #5 sys_clk_i = ~sys_clk_i;

  // =====================================================================
  // block and host model
  uhis_status u_uhis_status (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_rdata_o(reg_rdata), .interrupt_enable_mask_i(mask),
    .master_irq_enable_i(master), .ownership_request_bit_i(own_req),
    .root_hub_change_i(rhub), .frame_counter_i(fcnt),
    .shared_frame_copy_upd_i(fupd), .system_error_i(syserr),
    .resume_signal_i(rsm), .resume_by_sw_i(rsm_sw), .sof_issue_i(sof),
    .done_head_write_i(done), .sched_overrun_i(ovr), .irq_o(irq),
    .system_mgmt_irq_pin_o(smi), .halt_o(halt),
    .done_head_write_allow_o(allow), .overrun_count_o(ocnt));
  uhis_host_model u_uhis_host_model (
    .sys_clk_i(sys_clk_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
    .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
    .reg_rdata_i(reg_rdata));

  // =====================================================================
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] e);
    samples_checked++;
    if (seen !== e) begin
      err_total++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge sys_clk_i);
      #1;
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(2);
  endtask
  // read flags, compare them and the request level
  task automatic chk_flags();
    logic [31:0] d;
    u_uhis_host_model.rd(UHIS_OFS_FLAGS, d);
    chk(d, exp_f);
    chk({31'h0, irq}, {31'h0, master & |(exp_f & mask & 32'h7f)});
  endtask
  task automatic complete_run();
    if (err_total == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // =====================================================================
  // scenarios
  task automatic s_sof();
    exp_f = 32'h0;
    chk_flags();
    pulse(sof);
    exp_f = 32'h4;
    chk_flags();
    master = 1'b1;
    tick(1);
    chk_flags();
    mask = 32'h4000_007b;
    tick(1);
    chk_flags();
    mask = 32'h4000_007f;
    u_uhis_host_model.wr(8'h10, 32'h4);
    u_uhis_host_model.wr(UHIS_OFS_FLAGS, 32'h0);
    chk_flags();
    u_uhis_host_model.wr(UHIS_OFS_FLAGS, 32'h4);
    exp_f = 32'h0;
    chk_flags();
    // event and clearing write at one edge: the event wins
    fork
      u_uhis_host_model.wr(UHIS_OFS_FLAGS, 32'h4);
      pulse(sof);
    join
    exp_f = 32'h4;
    chk_flags();
    u_uhis_host_model.wr(UHIS_OFS_FLAGS, 32'h7f);
    exp_f = 32'h0;
    chk_flags();
  endtask
  task automatic s_events();
    own_req = 1'b1;
    tick(3);
    exp_f = 32'h4000_0000;
    chk_flags();
    chk({31'h0, smi}, 32'h1);
    master = 1'b0;
    tick(1);
    chk({31'h0, smi}, 32'h1);
    master = 1'b1;
    pulse(rhub);
    fcnt = 16'h8000;
    tick(3);
    exp_f = exp_f | 32'h60;
    chk_flags();
    rsm_sw = 1'b1;
    rsm = 1'b1;
    tick(3);
    chk_flags();
    rsm = 1'b0;
    rsm_sw = 1'b0;
    tick(2);
    rsm = 1'b1;
    tick(3);
    exp_f = exp_f | 32'h8;
    chk_flags();
    pulse(done);
    pulse(syserr);
    exp_f = exp_f | 32'h12;
    chk_flags();
    chk({30'h0, halt, allow}, 32'h2);
    // clearing the done flag lets the next write-back through
    u_uhis_host_model.wr(UHIS_OFS_FLAGS, 32'h2);
    exp_f = exp_f & ~32'h2;
    chk({31'h0, allow}, 32'h1);
  endtask
  task automatic s_ovr();
    chk({30'h0, ocnt}, {30'h0, UHIS_OVR_RESET});
    repeat (5) pulse(ovr);
    chk({30'h0, ocnt}, 32'h1);
    chk_flags();
    pulse(fupd);
    exp_f = exp_f | 32'h1;
    chk_flags();
    pulse(ovr);
    chk({30'h0, ocnt}, 32'h2);
  endtask
  task automatic s_rst();
    // fatal flag, left set so far, dropped by a controller reset
    rst_i = 1'b1;
    tick(4);
    rst_i = 1'b0;
    tick(1);
    exp_f = UHIS_FLAGS_RESET;
    chk_flags();
    chk({30'h0, halt, allow}, 32'h1);
  endtask

  // =====================================================================
  // main sequence and hang guard
  initial begin
    tick(4);
    rst_i = 1'b0;
    tick(1);
    s_sof();
    s_events();
    s_ovr();
    s_rst();
    complete_run();
  end
  initial begin
    #200000;
    err_total++;
    complete_run();
  end
endmodule

//--- verilog/uhis_edge.sv
// edge or toggle detector for one synchronous event level
`timescale 1ns/1ps
module uhis_edge
  import uhis_pkg::*;
#(
  parameter bit TOGGLE = 1'b0
) (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  // level in, pulse out
  input  wire logic sig_i,
  output logic      pulse_o
);

  uhis_edge_state_t st;
  uhis_edge_state_t next_st;

  // no pulse until one sample has been taken after reset
  always_comb begin
    next_st       = st;
    next_st.prev  = sig_i;
    next_st.armed = 1'b1;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // rising edge, or any change when toggle mode
  assign pulse_o = st.armed &
                   (TOGGLE ? (sig_i ^ st.prev) : (sig_i & ~st.prev));

endmodule

//--- verilog/uhis_status.sv
// interrupt event flag register with its set, clear and request logic
`timescale 1ns/1ps
module uhis_status
  import uhis_pkg::*;
#(
  parameter bit SMI_PRESENT = 1'b1
) (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // register port
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  output logic [31:0]      reg_rdata_o,
  // enables held elsewhere
  input  wire logic [31:0] interrupt_enable_mask_i,
  input  wire logic        master_irq_enable_i,
  // event sources
  input  wire logic        ownership_request_bit_i,
  input  wire logic        root_hub_change_i,
  input  wire logic [15:0] frame_counter_i,
  input  wire logic        shared_frame_copy_upd_i,
  input  wire logic        system_error_i,
  input  wire logic        resume_signal_i,
  input  wire logic        resume_by_sw_i,
  input  wire logic        sof_issue_i,
  input  wire logic        done_head_write_i,
  input  wire logic        sched_overrun_i,
  // results
  output logic             irq_o,
  output logic             system_mgmt_irq_pin_o,
  output logic             halt_o,
  output logic             done_head_write_allow_o,
  output logic [1:0]       overrun_count_o
);

  // ===================================================================
  // edge detection of level sources
  logic own_rise;
  logic rsm_rise;
  logic fwrap_tog;

  uhis_edge #(.TOGGLE(1'b0)) u_own_edge (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .sig_i     (ownership_request_bit_i),
    .pulse_o   (own_rise)
  );

  uhis_edge #(.TOGGLE(1'b0)) u_rsm_edge (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .sig_i     (resume_signal_i),
    .pulse_o   (rsm_rise)
  );

  uhis_edge #(.TOGGLE(1'b1)) u_fwrap_edge (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .sig_i     (frame_counter_i[15]),
    .pulse_o   (fwrap_tog)
  );

  // ===================================================================
  // gathered set requests and write clears
  uhis_state_t st;
  uhis_state_t next_st;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic        wr_hit;
  logic        rd_hit;
  logic        ovr_set;

  assign wr_hit = reg_wr_i & (reg_addr_i == UHIS_OFS_FLAGS);
  assign rd_hit = reg_rd_i & (reg_addr_i == UHIS_OFS_FLAGS);

  // overrun flag waits for the frame copy update
  assign ovr_set = shared_frame_copy_upd_i &
                   (st.ovr_pend | sched_overrun_i);

  always_comb begin
    set_vec = '0;
    set_vec[UHIS_BIT_OWN]  = own_rise & SMI_PRESENT;
    set_vec[UHIS_BIT_RHUB] = root_hub_change_i;
    set_vec[UHIS_BIT_FWRP] = fwrap_tog;
    set_vec[UHIS_BIT_FATL] = system_error_i;
    set_vec[UHIS_BIT_RSM]  = rsm_rise & ~resume_by_sw_i;
    set_vec[UHIS_BIT_SOF]  = sof_issue_i;
    set_vec[UHIS_BIT_DONE] = done_head_write_i;
    set_vec[UHIS_BIT_OVR]  = ovr_set;
  end

  // reserved bits of the write are dropped
  assign clr_vec = wr_hit ? (reg_wdata_i & UHIS_IMPL_MASK) : '0;

  // ===================================================================
  // next state
  always_comb begin
    next_st = st;
    // write one clears, event set wins over a clear in the same cycle
    next_st.flags = ((st.flags & ~clr_vec) | set_vec)
                    & UHIS_IMPL_MASK;
    if (!SMI_PRESENT) begin
      next_st.flags[UHIS_BIT_OWN] = 1'b0;
    end
    // counter counts every overrun and wraps naturally
    if (sched_overrun_i) begin
      next_st.ovr_cnt = st.ovr_cnt + 2'h1;
    end
    // remember an overrun until the frame copy update
    if (shared_frame_copy_upd_i) begin
      next_st.ovr_pend = 1'b0;
    end else if (sched_overrun_i) begin
      next_st.ovr_pend = 1'b1;
    end
    // registered read data
    next_st.rdata = rd_hit ? (st.flags & UHIS_IMPL_MASK) : '0;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st.flags    <= UHIS_FLAGS_RESET;
      st.ovr_cnt  <= UHIS_OVR_RESET;
      st.ovr_pend <= 1'b0;
      st.rdata    <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ===================================================================
  // outputs
  logic [31:0] active;
  assign active = st.flags & interrupt_enable_mask_i;

  // level request over all flags but ownership change
  assign irq_o = master_irq_enable_i &
                 (|(active & ~(32'h1 << UHIS_BIT_OWN)));
  // ownership change bypasses the master enable
  assign system_mgmt_irq_pin_o = active[UHIS_BIT_OWN];
  // processing stops while the fatal flag stands
  assign halt_o = st.flags[UHIS_BIT_FATL];
  // next write-back only after software cleared the flag
  assign done_head_write_allow_o = ~st.flags[UHIS_BIT_DONE];
  assign overrun_count_o = st.ovr_cnt;
  assign reg_rdata_o     = st.rdata;

  // ===================================================================
  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_clear_write(int b);
    wr_hit && reg_wdata_i[b];
  endsequence

  sequence s_no_set(int b);
    !set_vec[b];
  endsequence

  AST_EVENT_SETS: assert property (
    root_hub_change_i |=> st.flags[UHIS_BIT_RHUB])
    else $error("root hub change did not set its flag");

  AST_IRQ_GATED: assert property (
    irq_o |-> master_irq_enable_i && (|active[29:0]))
    else $error("interrupt without enabled flag and master enable");

  AST_W1C: assert property (
    s_clear_write(UHIS_BIT_SOF) ##0 s_no_set(UHIS_BIT_SOF)
    |=> !st.flags[UHIS_BIT_SOF])
    else $error("write of one did not clear the flag");

  AST_NO_SELF_CLEAR: assert property (
    st.flags[UHIS_BIT_RHUB] && !(wr_hit && reg_wdata_i[UHIS_BIT_RHUB])
    |=> st.flags[UHIS_BIT_RHUB])
    else $error("flag dropped without a clearing write");

  AST_SET_WINS: assert property (
    wr_hit && sof_issue_i |=> st.flags[UHIS_BIT_SOF])
    else $error("event lost against a clearing write");

  AST_OWN_SET: assert property (
    !$past(rst_i) && $rose(ownership_request_bit_i) && SMI_PRESENT
    |=> st.flags[UHIS_BIT_OWN])
    else $error("ownership request did not set its flag");

  AST_SMI_NOW: assert property (
    st.flags[UHIS_BIT_OWN] && interrupt_enable_mask_i[UHIS_BIT_OWN]
    |-> system_mgmt_irq_pin_o)
    else $error("enabled ownership change without management interrupt");

  AST_OWN_ZERO: assert property (
    !SMI_PRESENT |-> !st.flags[UHIS_BIT_OWN])
    else $error("ownership flag set without management pin");

  AST_RESUME_SW: assert property (
    resume_by_sw_i && !st.flags[UHIS_BIT_RSM]
    |=> !st.flags[UHIS_BIT_RSM])
    else $error("software resume set the resume flag");

  AST_DONE_HOLD: assert property (
    done_head_write_i |=> !done_head_write_allow_o)
    else $error("write-back allowed while done head flag set");

  AST_OVR_COUNT: assert property (
    sched_overrun_i |=> overrun_count_o == $past(overrun_count_o) + 2'h1)
    else $error("overrun counter did not advance");

  // overrun waits for the copy update, then the flag follows
  sequence s_overrun_waits;
    sched_overrun_i && !shared_frame_copy_upd_i;
  endsequence

  sequence s_copy_update;
    shared_frame_copy_upd_i;
  endsequence

  AST_OVR_PEND: assert property (
    s_overrun_waits |=> st.ovr_pend)
    else $error("overrun not remembered until the frame copy update");

  AST_OVR_FLAG: assert property (
    st.ovr_pend ##0 s_copy_update |=> st.flags[UHIS_BIT_OVR])
    else $error("overrun flag not set at frame copy update");

  // level sources: edges on the first sample after reset are ignored
  AST_FWRAP_SET: assert property (
    !$past(rst_i) && $changed(frame_counter_i[15])
    |=> st.flags[UHIS_BIT_FWRP])
    else $error("frame counter top bit change did not set its flag");

  AST_RESUME_SET: assert property (
    !$past(rst_i) && $rose(resume_signal_i) && !resume_by_sw_i
    |=> st.flags[UHIS_BIT_RSM])
    else $error("device resume did not set the resume flag");

  AST_SOF_SET: assert property (
    sof_issue_i |=> st.flags[UHIS_BIT_SOF])
    else $error("frame start did not set its flag");

  AST_DONE_SET: assert property (
    done_head_write_i |=> st.flags[UHIS_BIT_DONE])
    else $error("done head write-back did not set its flag");

  AST_HALT: assert property (
    system_error_i |=> halt_o)
    else $error("system error did not halt processing");

endmodule
